// ### rtl/rst_ctrl_pkg.sv
// Constants shared by the reset and stop mode recovery controller
// ****************************************************************
// Contract
// - Power-on detection places the device in system reset.
// - Supply below the safe level causes a brown-out system reset.
// - Watchdog time-out resets only when the reset-select option bit is set.
// - Reset pin resets only while its alternate reset function is enabled.
// - Writing 1 to debugger control bit 0 performs a system reset.
// - In STOP mode a watchdog time-out starts a stop mode recovery.
// - In STOP mode a change on an enabled recovery input starts recovery.
// - Stop mode recovery is a distinct reset type, not a system reset.
// - Crystal oscillator enabled lengthens the system reset duration.
// - Reset pin pulses shorter than three clocks are ignored.
// - Reset is held until the power-on counter expires after power-up.
// - After power-on reset the power-on flag in watchdog control is 1.
// - A debugger reset leaves the debugger unit itself untouched.
// ****************************************************************
package rst_ctrl_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] OFS_DBG_CTL = 8'h00;
  localparam logic [7:0] OFS_WDT_CTL = 8'h04;
  localparam logic [7:0] OFS_CAUSE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_SMR_EN = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DBG_RESET_BIT = 0;
  localparam int POR_FLAG_BIT = 0;
  localparam int CAUSE_W = 6;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_BO = 1;
  localparam int CAUSE_WDT = 2;
  localparam int CAUSE_PIN = 3;
  localparam int CAUSE_DBG = 4;
  localparam int CAUSE_SMR = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h00;
  localparam logic [CAUSE_W-1:0] MASK_RST = 6'h00;
  localparam logic [7:0] SMR_EN_RST = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_TIME_NS = 2000;
  localparam int XTAL_TIME_NS = 16000;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XTAL_CYCLES = (XTAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_MIN_CYCLES = 3;
  localparam int TIMER_W = 12;

  // Controller states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_RECOVER = 3'b100
  } rst_state_t;

endpackage : rst_ctrl_pkg

// ### rtl/sync3_filter.sv
// Three-stage synchroniser whose output follows only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sync3_filter #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous inputs and their filtered image
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] q_q;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Output bit updates only where the two settled stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= RESET_VAL;
    end else begin
      q_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_q);
    end
  end

  assign q_o = q_q;

endmodule : sync3_filter
`default_nettype wire

// ### rtl/reset_timer.sv
// Down counter that stretches the system reset after the last request
`timescale 1ns/1ps
`default_nettype none
module reset_timer #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Load strobe and length
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  // Progress
  output logic busy_o,
  output logic [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] count_q;

  // Reloads every cycle a request is held, so counting starts on release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else if (load_i) begin
      count_q <= value_i;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign busy_o = (count_q != '0);
  assign count_o = count_q;

endmodule : reset_timer
`default_nettype wire

// ### rtl/reset_stop_recovery_control.sv
// Reset and stop mode recovery controller with a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module reset_stop_recovery_control #(
  parameter int GPIO_W = 8,
  parameter int RESET_CYCLES_P = rst_ctrl_pkg::RESET_CYCLES,
  parameter int XTAL_CYCLES_P = rst_ctrl_pkg::XTAL_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous reset sources
  input wire logic por_detect_i,
  input wire logic brownout_detect_i,
  input wire logic wdt_timeout_i,
  input wire logic reset_pin_n_i,
  input wire logic [GPIO_W-1:0] gpio_i,
  // Static configuration from option bits and port setup
  input wire logic watchdog_reset_select_i,
  input wire logic reset_pin_af_en_i,
  input wire logic xtal_enable_i,
  // Core power mode
  input wire logic stop_mode_i,
  // Reset outputs
  output logic sys_rst_o,
  output logic debugger_rst_o,
  output logic stop_recovery_o,
  // Interrupt
  output logic irq_o
);

  localparam int SYNC_W = GPIO_W + 4;
  localparam int PIN_CNT_W = 2;
  localparam logic [PIN_CNT_W-1:0] PIN_LAST = PIN_CNT_W'(rst_ctrl_pkg::PIN_MIN_CYCLES - 1);
  localparam logic [rst_ctrl_pkg::TIMER_W-1:0] RESET_LOAD =
    rst_ctrl_pkg::TIMER_W'(RESET_CYCLES_P);
  localparam logic [rst_ctrl_pkg::TIMER_W-1:0] XTAL_LOAD =
    rst_ctrl_pkg::TIMER_W'(XTAL_CYCLES_P);
  // Pin idles high, all other sources idle low
  localparam logic [SYNC_W-1:0] SYNC_RST = {{GPIO_W{1'b0}}, 4'h8};

  // ****************************************************************
  // Synchronisation of asynchronous sources
  // ****************************************************************
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_s;
  logic por_s;
  logic bo_s;
  logic wdt_s;
  logic pin_n_s;
  logic [GPIO_W-1:0] gpio_s;

  assign sync_raw = {gpio_i, reset_pin_n_i, wdt_timeout_i, brownout_detect_i, por_detect_i};

  // All asynchronous inputs pass the same filter before use
  sync3_filter #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sync_raw),
    .q_o(sync_s)
  );

  assign por_s = sync_s[0];
  assign bo_s = sync_s[1];
  assign wdt_s = sync_s[2];
  assign pin_n_s = sync_s[3];
  assign gpio_s = sync_s[SYNC_W-1:4];

  // ****************************************************************
  // Edge detection and pin width filter
  // ****************************************************************
  logic wdt_prev_q;
  logic [GPIO_W-1:0] gpio_prev_q;
  logic [PIN_CNT_W-1:0] pin_cnt_q;
  logic wdt_rise;
  logic pin_act;
  logic pin_req;
  logic wdt_rst_req;
  logic [GPIO_W-1:0] gpio_chg;
  logic [GPIO_W-1:0] smr_en_q;
  logic smr_evt;

  // Previous levels for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_prev_q <= 1'b0;
      gpio_prev_q <= '0;
    end else begin
      wdt_prev_q <= wdt_s;
      gpio_prev_q <= gpio_s;
    end
  end

  assign wdt_rise = wdt_s & ~wdt_prev_q;
  assign pin_act = ~pin_n_s & reset_pin_af_en_i;

  // Counts consecutive low cycles; any gap restarts the count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_cnt_q <= '0;
    end else if (!pin_act) begin
      pin_cnt_q <= '0;
    end else if (pin_cnt_q != PIN_LAST) begin
      pin_cnt_q <= pin_cnt_q + 1'b1;
    end
  end

  assign pin_req = pin_act && (pin_cnt_q == PIN_LAST);
  // Time-out resets only in run mode with reset behaviour selected
  assign wdt_rst_req = wdt_rise & watchdog_reset_select_i & ~stop_mode_i;
  // Disabled recovery pins are masked out
  assign gpio_chg = (gpio_s ^ gpio_prev_q) & smr_en_q;
  assign smr_evt = stop_mode_i & (wdt_rise | (|gpio_chg));

  // ****************************************************************
  // Request combination and sequencing
  // ****************************************************************
  rst_ctrl_pkg::rst_state_t state_q;
  rst_ctrl_pkg::rst_state_t state_d;
  logic dbg_req;
  logic any_req;
  logic smr_go;
  logic start;
  logic release_rst;
  logic timer_busy;
  logic [rst_ctrl_pkg::TIMER_W-1:0] timer_cnt;
  logic [rst_ctrl_pkg::TIMER_W-1:0] load_val;
  logic [rst_ctrl_pkg::CAUSE_W-1:0] req_vec;

  assign any_req = por_s | bo_s | wdt_rst_req | pin_req | dbg_req;
  assign smr_go = (state_q == rst_ctrl_pkg::ST_RUN) && !any_req && smr_evt;
  assign start = (state_q != rst_ctrl_pkg::ST_HOLD) && any_req;
  assign release_rst = (state_q == rst_ctrl_pkg::ST_HOLD) && !any_req && !timer_busy;
  // Longer hold gives the crystal time to start
  assign load_val = xtal_enable_i ? XTAL_LOAD : RESET_LOAD;

  reset_timer #(
    .WIDTH(rst_ctrl_pkg::TIMER_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(any_req),
    .value_i(load_val),
    .busy_o(timer_busy),
    .count_o(timer_cnt)
  );

  // Next state: reset wins over recovery when both arrive together
  always_comb begin
    state_d = state_q;
    case (state_q)
      rst_ctrl_pkg::ST_RUN: begin
        if (any_req) begin
          state_d = rst_ctrl_pkg::ST_HOLD;
        end else if (smr_go) begin
          state_d = rst_ctrl_pkg::ST_RECOVER;
        end
      end
      rst_ctrl_pkg::ST_HOLD: begin
        if (release_rst) begin
          state_d = rst_ctrl_pkg::ST_RUN;
        end
      end
      rst_ctrl_pkg::ST_RECOVER: begin
        state_d = any_req ? rst_ctrl_pkg::ST_HOLD : rst_ctrl_pkg::ST_RUN;
      end
      default: begin
        state_d = rst_ctrl_pkg::ST_HOLD;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= rst_ctrl_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  assign sys_rst_o = (state_q == rst_ctrl_pkg::ST_HOLD);
  assign stop_recovery_o = (state_q == rst_ctrl_pkg::ST_RECOVER);

  // Debugger unit sees only supply-driven resets, never its own request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debugger_rst_o <= 1'b1;
    end else begin
      debugger_rst_o <= por_s | bo_s;
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_val;
  logic wr_fire;
  logic dbg_ctl_q;
  logic por_pend_q;
  logic por_flag_q;
  logic [rst_ctrl_pkg::CAUSE_W-1:0] cause_q;
  logic [rst_ctrl_pkg::CAUSE_W-1:0] stat_q;
  logic [rst_ctrl_pkg::CAUSE_W-1:0] mask_q;
  logic [rst_ctrl_pkg::CAUSE_W-1:0] req_prev_q;
  logic [rst_ctrl_pkg::CAUSE_W-1:0] ev_vec;
  logic [rst_ctrl_pkg::CAUSE_W-1:0] stat_clr;
  logic por_clr;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // Write lands on the edge where the master sees ack
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (wb_adr_i)
      rst_ctrl_pkg::OFS_DBG_CTL: rd_val[rst_ctrl_pkg::DBG_RESET_BIT] = dbg_ctl_q;
      rst_ctrl_pkg::OFS_WDT_CTL: rd_val[rst_ctrl_pkg::POR_FLAG_BIT] = por_flag_q;
      rst_ctrl_pkg::OFS_CAUSE: rd_val[rst_ctrl_pkg::CAUSE_W-1:0] = cause_q;
      rst_ctrl_pkg::OFS_IRQ_STAT: rd_val[rst_ctrl_pkg::CAUSE_W-1:0] = stat_q;
      rst_ctrl_pkg::OFS_IRQ_MASK: rd_val[rst_ctrl_pkg::CAUSE_W-1:0] = mask_q;
      rst_ctrl_pkg::OFS_SMR_EN: rd_val[GPIO_W-1:0] = smr_en_q;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read data captured at the first edge, stable through ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      dat_q <= rd_val;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;

  // ****************************************************************
  // Software registers
  // ****************************************************************
  assign dbg_req = wr_fire && (wb_adr_i == rst_ctrl_pkg::OFS_DBG_CTL) &&
                   wb_dat_i[rst_ctrl_pkg::DBG_RESET_BIT];

  // Debugger reset bit reads 1 until the reset it started is released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbg_ctl_q <= 1'b0;
    end else if (dbg_req) begin
      dbg_ctl_q <= 1'b1;
    end else if (release_rst) begin
      dbg_ctl_q <= 1'b0;
    end
  end

  // Mask and recovery enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= rst_ctrl_pkg::MASK_RST;
      smr_en_q <= GPIO_W'(rst_ctrl_pkg::SMR_EN_RST);
    end else if (wr_fire) begin
      if (wb_adr_i == rst_ctrl_pkg::OFS_IRQ_MASK) begin
        mask_q <= wb_dat_i[rst_ctrl_pkg::CAUSE_W-1:0];
      end
      if (wb_adr_i == rst_ctrl_pkg::OFS_SMR_EN) begin
        smr_en_q <= wb_dat_i[GPIO_W-1:0];
      end
    end
  end

  // Remember a power-on until its reset is released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_pend_q <= 1'b1;
    end else if (por_s) begin
      por_pend_q <= 1'b1;
    end else if (release_rst) begin
      por_pend_q <= 1'b0;
    end
  end

  assign por_clr = wr_fire && (wb_adr_i == rst_ctrl_pkg::OFS_WDT_CTL) &&
                   wb_dat_i[rst_ctrl_pkg::POR_FLAG_BIT];

  // Power-on flag: set at release, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_flag_q <= 1'b0;
    end else if (release_rst && por_pend_q) begin
      por_flag_q <= 1'b1;
    end else if (por_clr) begin
      por_flag_q <= 1'b0;
    end
  end

  // Request vector in cause-bit order
  always_comb begin
    req_vec = '0;
    req_vec[rst_ctrl_pkg::CAUSE_POR] = por_s;
    req_vec[rst_ctrl_pkg::CAUSE_BO] = bo_s;
    req_vec[rst_ctrl_pkg::CAUSE_WDT] = wdt_rst_req;
    req_vec[rst_ctrl_pkg::CAUSE_PIN] = pin_req;
    req_vec[rst_ctrl_pkg::CAUSE_DBG] = dbg_req;
    req_vec[rst_ctrl_pkg::CAUSE_SMR] = smr_go;
  end

  // Cause: fresh at each new reset, accumulated while held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_q <= rst_ctrl_pkg::CAUSE_RST;
    end else if (start || smr_go) begin
      cause_q <= req_vec;
    end else if (state_q == rst_ctrl_pkg::ST_HOLD) begin
      cause_q <= cause_q | req_vec;
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // Levels like power-on count once, on their rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_prev_q <= '0;
    end else begin
      req_prev_q <= req_vec;
    end
  end

  assign ev_vec = req_vec & ~req_prev_q;
  assign stat_clr = (wr_fire && (wb_adr_i == rst_ctrl_pkg::OFS_IRQ_STAT)) ?
                    wb_dat_i[rst_ctrl_pkg::CAUSE_W-1:0] : '0;

  // Sticky status, an event in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | ev_vec;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_por_gone;
    $fell(por_s);
  endsequence

  sequence s_hold_four;
    sys_rst_o [*4];
  endsequence

  sequence s_pin_low3;
    pin_act [*3];
  endsequence

  a_por_holds_reset: assert property (por_s |=> sys_rst_o)
    else $error("power-on did not hold reset");
  a_brownout_reset: assert property (bo_s |=> sys_rst_o && cause_q[rst_ctrl_pkg::CAUSE_BO])
    else $error("brown-out did not reset");
  a_wdt_select_reset: assert property (wdt_rise && !stop_mode_i &&
    watchdog_reset_select_i |=> sys_rst_o && cause_q[rst_ctrl_pkg::CAUSE_WDT])
    else $error("selected watchdog did not reset");
  a_pin_enable_gate: assert property (pin_req |-> reset_pin_af_en_i)
    else $error("pin reset while function disabled");
  a_debug_reset: assert property (dbg_req |=> sys_rst_o && dbg_ctl_q)
    else $error("debugger write did not reset");
  a_wdt_recovery: assert property (stop_mode_i && wdt_rise && !any_req &&
    state_q == rst_ctrl_pkg::ST_RUN |=> stop_recovery_o)
    else $error("watchdog did not start recovery");
  a_gpio_recovery: assert property (stop_mode_i && gpio_chg != '0 && !any_req &&
    state_q == rst_ctrl_pkg::ST_RUN |=> stop_recovery_o && cause_q[rst_ctrl_pkg::CAUSE_SMR])
    else $error("enabled pin change did not recover");
  a_recovery_distinct: assert property (smr_go |=> stop_recovery_o && !sys_rst_o &&
    cause_q[rst_ctrl_pkg::CAUSE_SMR])
    else $error("recovery looked like system reset");
  a_xtal_longer: assert property ((any_req && xtal_enable_i) ##1 !any_req |->
    timer_cnt == XTAL_LOAD)
    else $error("crystal hold length wrong");
  a_pin_width: assert property (s_pin_low3 |-> pin_req)
    else $error("three-cycle pin pulse missed");
  a_pin_short: assert property (pin_req |-> $past(pin_act) && $past(pin_act, 2))
    else $error("short pin pulse caused reset");
  a_por_count: assert property (s_por_gone |-> s_hold_four)
    else $error("reset released before counter");
  a_release_clean: assert property ($fell(sys_rst_o) |->
    $past(timer_cnt) == '0 && !$past(any_req))
    else $error("reset released early");
  a_por_flag: assert property (release_rst && por_pend_q |=> por_flag_q)
    else $error("power-on flag not set");
  a_debugger_kept: assert property (dbg_req && !por_s && !bo_s |=> !debugger_rst_o)
    else $error("debugger unit reset by itself");
  a_or_combine: assert property (any_req |=> sys_rst_o)
    else $error("request did not reset");
  a_cause_record: assert property (start && pin_req |=> cause_q[rst_ctrl_pkg::CAUSE_PIN])
    else $error("cause not recorded");

endmodule : reset_stop_recovery_control
`default_nettype wire

// ### testbench/far_side_model.sv
// Behavioural far side: watchdog, port pins, reset pin and core power mode
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
  parameter int GPIO_W = 8
) (
  // Clock
  input wire logic clk_i,
  // Stimulus toward the controller
  output logic wdt_timeout_o,
  output logic reset_pin_n_o,
  output logic [GPIO_W-1:0] gpio_o,
  output logic stop_mode_o
);
  // ****************************************************************
  // Idle levels and events
  // ****************************************************************
  // Reset pin has a pull-up, so it idles high
  initial begin
    wdt_timeout_o = 1'b0;
    reset_pin_n_o = 1'b1;
    gpio_o = '0;
    stop_mode_o = 1'b0;
  end
  // Time-out level stays up for n clocks, as a slow domain would hold it
  task automatic fire_wdt(input int n);
    wdt_timeout_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    wdt_timeout_o <= 1'b0;
    @(posedge clk_i);
  endtask : fire_wdt
  // Low pulse on the reset pin, n clocks wide
  task automatic pin_low(input int n);
    reset_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    reset_pin_n_o <= 1'b1;
    @(posedge clk_i);
  endtask : pin_low
  // One port pin changes level and keeps it
  task automatic flip_gpio(input int b);
    gpio_o[b] <= ~gpio_o[b];
    @(posedge clk_i);
  endtask : flip_gpio
  // Core enters or leaves STOP
  task automatic set_stop(input logic v);
    stop_mode_o <= v;
    @(posedge clk_i);
  endtask : set_stop
endmodule : far_side_model
`default_nettype wire

// ### testbench/reset_stop_recovery_control_bench.sv
// Self-checking bench for the reset and stop mode recovery controller
`timescale 1ns/1ps
`default_nettype none
module reset_stop_recovery_control_bench;
  // ****************************************************************
  // Signals, clock and monitors
  // ****************************************************************
  localparam int RST_N = 4;
  localparam int XTAL_N = 12;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic por_detect_i, brownout_detect_i, wdt_timeout_i, reset_pin_n_i;
  logic [7:0] gpio_i;
  logic watchdog_reset_select_i, reset_pin_af_en_i, xtal_enable_i, stop_mode_i;
  logic sys_rst_o, debugger_rst_o, stop_recovery_o, irq_o;
  int error_cnt = 0;
  int cmp_count = 0;
  int rst_cnt = 0;
  int smr_cnt = 0;
  int dbg_cnt = 0;
  int d0, len_a;
  // Short hold counts keep the run brief
  reset_stop_recovery_control #(.GPIO_W(8), .RESET_CYCLES_P(RST_N), .XTAL_CYCLES_P(XTAL_N)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .por_detect_i(por_detect_i), .brownout_detect_i(brownout_detect_i),
    .wdt_timeout_i(wdt_timeout_i), .reset_pin_n_i(reset_pin_n_i), .gpio_i(gpio_i),
    .watchdog_reset_select_i(watchdog_reset_select_i), .reset_pin_af_en_i(reset_pin_af_en_i),
    .xtal_enable_i(xtal_enable_i), .stop_mode_i(stop_mode_i), .sys_rst_o(sys_rst_o),
    .debugger_rst_o(debugger_rst_o), .stop_recovery_o(stop_recovery_o), .irq_o(irq_o));
  far_side_model #(.GPIO_W(8)) PARTNER (.clk_i(clk_i), .wdt_timeout_o(wdt_timeout_i),
    .reset_pin_n_o(reset_pin_n_i), .gpio_o(gpio_i), .stop_mode_o(stop_mode_i));
  // 125 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Recovery is a one-cycle pulse, so outputs are counted at every edge
  always @(posedge clk_i) begin
    if (sys_rst_o === 1'b1) rst_cnt++;
    if (stop_recovery_o === 1'b1) smr_cnt++;
    if (debugger_rst_o === 1'b1) dbg_cnt++;
  end
  // ****************************************************************
  // Shared tasks and scenarios
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Classic single cycle; entered just after an edge, leaves one idle cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n == 50) chk("bus ack", 32'h1, 32'h0);
  endtask : wb_xfer
  task automatic rdc(input string nm, input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc
  // Waits out filter latency and any reset, then judges
  task automatic settle(input string nm, input logic er, input int es);
    int r0, s0, n;
    r0 = rst_cnt;
    s0 = smr_cnt;
    n = 0;
    repeat (12) @(posedge clk_i);
    while (sys_rst_o === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 3000) chk({nm, " release"}, 32'h1, 32'h0);
    chk({nm, " reset"}, {31'h0, er}, {31'h0, rst_cnt != r0});
    chk({nm, " recovery"}, 32'(es), 32'(smr_cnt - s0));
  endtask : settle
  task automatic t_sources();
    repeat (20) @(posedge clk_i);
    chk("por sys_rst", 32'h1, {31'h0, sys_rst_o});
    chk("por dbg_rst", 32'h1, {31'h0, debugger_rst_o});
    d0 = rst_cnt;
    por_detect_i <= 1'b0;
    settle("por", 1'b1, 0);
    chk("por hold", 32'h1, {31'h0, rst_cnt - d0 >= RST_N});
    rdc("por flag", rst_ctrl_pkg::OFS_WDT_CTL, 32'h1);
    rdc("por cause", rst_ctrl_pkg::OFS_CAUSE, 32'h1);
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_WDT_CTL, 32'h1);
    rdc("por flag clr", rst_ctrl_pkg::OFS_WDT_CTL, 32'h0);
    rdc("unmapped", 8'h3c, 32'h0);
    d0 = dbg_cnt;
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_DBG_CTL, 32'h1);
    settle("dbg", 1'b1, 0);
    chk("dbg unit kept", 32'h0, 32'(dbg_cnt - d0));
    rdc("dbg cause", rst_ctrl_pkg::OFS_CAUSE, 32'h10);
    brownout_detect_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    brownout_detect_i <= 1'b0;
    settle("brownout", 1'b1, 0);
    rdc("bo cause", rst_ctrl_pkg::OFS_CAUSE, 32'h02);
    PARTNER.fire_wdt(6);
    settle("wdt off", 1'b0, 0);
    watchdog_reset_select_i <= 1'b1;
    PARTNER.fire_wdt(6);
    settle("wdt on", 1'b1, 0);
    rdc("wdt cause", rst_ctrl_pkg::OFS_CAUSE, 32'h04);
    PARTNER.pin_low(10);
    settle("pin off", 1'b0, 0);
    reset_pin_af_en_i <= 1'b1;
    PARTNER.pin_low(2);
    settle("pin short", 1'b0, 0);
    PARTNER.pin_low(8);
    settle("pin long", 1'b1, 0);
    rdc("pin cause", rst_ctrl_pkg::OFS_CAUSE, 32'h08);
    $display("test sources done");
  endtask : t_sources
  task automatic t_stop();
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_IRQ_STAT, 32'h3f);
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_SMR_EN, 32'h04);
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_IRQ_MASK, 32'h20);
    PARTNER.set_stop(1'b1);
    PARTNER.flip_gpio(5);
    settle("gpio off", 1'b0, 0);
    PARTNER.flip_gpio(2);
    settle("gpio on", 1'b0, 1);
    rdc("smr cause", rst_ctrl_pkg::OFS_CAUSE, 32'h20);
    chk("irq set", 32'h1, {31'h0, irq_o});
    rdc("irq status", rst_ctrl_pkg::OFS_IRQ_STAT, 32'h20);
    wb_sel_i <= 4'he;
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_IRQ_MASK, 32'h00);
    wb_sel_i <= 4'hf;
    chk("sel dropped", 32'h1, {31'h0, irq_o});
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_IRQ_MASK, 32'h00);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_IRQ_MASK, 32'h20);
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_IRQ_STAT, 32'h20);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    fork
      PARTNER.fire_wdt(6);
      settle("wdt stop", 1'b0, 1);
    join
    PARTNER.set_stop(1'b0);
    $display("test stop done");
  endtask : t_stop
  task automatic t_xtal();
    d0 = rst_cnt;
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_DBG_CTL, 32'h1);
    settle("short hold", 1'b1, 0);
    len_a = rst_cnt - d0;
    xtal_enable_i <= 1'b1;
    d0 = rst_cnt;
    wb_xfer(1'b1, rst_ctrl_pkg::OFS_DBG_CTL, 32'h1);
    settle("long hold", 1'b1, 0);
    chk("xtal extra", 32'(XTAL_N - RST_N), 32'(rst_cnt - d0 - len_a));
    $display("test xtal done");
  endtask : t_xtal
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // Supply starts low; reset held 10 cycles
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    por_detect_i = 1'b1;
    {brownout_detect_i, watchdog_reset_select_i, reset_pin_af_en_i, xtal_enable_i} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_sources();
    t_stop();
    t_xtal();
    stop_test();
  end
  // Run needs about 300 cycles; a hang is cut well beyond that
  initial begin
    #200000;
    error_cnt++;
    $display("ERROR run expected finish seen timeout");
    stop_test();
  end
endmodule : reset_stop_recovery_control_bench
`default_nettype wire
